/* design/hhdr_pkg.sv */
package hhdr_pkg;
  // Other-speed configuration descriptor
  localparam logic [7:0]  OSC_LEN         = 8'h09;
  localparam logic [7:0]  OSC_TYPE        = 8'h07;
  localparam logic [15:0] TOTAL_LEN_STT   = 16'h0019;
  localparam logic [15:0] TOTAL_LEN_MTT   = 16'h0029;
  localparam logic [7:0]  NUM_IF_STT      = 8'h01;
  localparam logic [7:0]  NUM_IF_MTT      = 8'h02;
  localparam logic [7:0]  CFG_VALUE       = 8'h01;
  localparam logic [7:0]  CFG_STR_IDX     = 8'h00;
  localparam logic [7:0]  ATTR_BUS        = 8'hA0;
  localparam logic [7:0]  ATTR_SELF       = 8'hE0;
  // Interface descriptor
  localparam logic [7:0]  IF_LEN          = 8'h09;
  localparam logic [7:0]  IF_TYPE         = 8'h04;
  localparam logic [7:0]  IF_NUMBER       = 8'h00;
  localparam logic [7:0]  IF_ALT_STT      = 8'h00;
  localparam logic [7:0]  IF_ALT_MTT      = 8'h01;
  localparam logic [7:0]  IF_NUM_EP       = 8'h01;
  localparam logic [7:0]  IF_CLASS        = 8'h09;
  localparam logic [7:0]  IF_SUBCLASS     = 8'h00;
  localparam logic [7:0]  IF_PROTO_ONE    = 8'h00;
  localparam logic [7:0]  IF_PROTO_TWO    = 8'h01;
  localparam logic [7:0]  IF_PROTO_MTT    = 8'h02;
  localparam logic [7:0]  IF_STR_IDX      = 8'h00;
  // Status-change endpoint descriptor
  localparam logic [7:0]  EP_LEN          = 8'h07;
  localparam logic [7:0]  EP_TYPE         = 8'h05;
  localparam logic [7:0]  EP_ADDR         = 8'h81;
  localparam logic [7:0]  EP_ATTR         = 8'h03;
  localparam logic [15:0] EP_MAX_PKT      = 16'h0001;
  localparam logic [7:0]  EP_INTERVAL     = 8'h0C;
  // Layout of the stream: cfg 0..8, if 9..17, ep 18..24, mtt if 25..33, mtt ep 34..40
  localparam logic [5:0]  OFS_IF_STT      = 6'h09;
  localparam logic [5:0]  OFS_EP_STT      = 6'h12;
  localparam logic [5:0]  OFS_IF_MTT      = 6'h19;
  localparam logic [5:0]  OFS_EP_MTT      = 6'h22;
  localparam logic [5:0]  OFS_END         = 6'h29;
  // Register map, word aligned byte addresses
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_POWER       = 4'h4;
  localparam logic [3:0]  REG_STATUS      = 4'h8;
  localparam logic [3:0]  REG_DATA        = 4'hC;
  localparam logic [7:0]  MAXP_BUS_RST    = 8'h32;
  localparam logic [7:0]  MAXP_SELF_RST   = 8'h01;
  localparam logic [31:0] UNMAPPED_VALUE  = 32'h0000_0000;
endpackage : hhdr_pkg

/* design/hhdr_byte_rom.sv */
`timescale 1ns/10ps
module hhdr_byte_rom (
  input  wire logic [5:0] idx,
  input  wire logic       self_pwr,
  input  wire logic       mtt,
  input  wire logic [7:0] maxp_bus,
  input  wire logic [7:0] maxp_self,
  output logic [7:0]      data
);
  function automatic logic [7:0] lsb_first(input logic [15:0] v, input logic hi);
    lsb_first = hi ? v[15:8] : v[7:0];
  endfunction : lsb_first

  wire logic [15:0] total_len = mtt ? hhdr_pkg::TOTAL_LEN_MTT : hhdr_pkg::TOTAL_LEN_STT;
  wire logic [7:0]  num_if    = mtt ? hhdr_pkg::NUM_IF_MTT : hhdr_pkg::NUM_IF_STT;
  wire logic [7:0]  attr      = self_pwr ? hhdr_pkg::ATTR_SELF : hhdr_pkg::ATTR_BUS;
  wire logic [7:0]  maxp      = self_pwr ? maxp_self : maxp_bus;
  wire logic [7:0]  proto_stt = (num_if == hhdr_pkg::NUM_IF_MTT) ? hhdr_pkg::IF_PROTO_TWO
                                                                  : hhdr_pkg::IF_PROTO_ONE;
  wire logic        in_mtt    = idx >= hhdr_pkg::OFS_IF_MTT;
  wire logic [5:0]  rel_if    = in_mtt ? idx - hhdr_pkg::OFS_IF_MTT : idx - hhdr_pkg::OFS_IF_STT;
  wire logic [5:0]  rel_ep    = in_mtt ? idx - hhdr_pkg::OFS_EP_MTT : idx - hhdr_pkg::OFS_EP_STT;
  wire logic        is_ep     = in_mtt ? idx >= hhdr_pkg::OFS_EP_MTT : idx >= hhdr_pkg::OFS_EP_STT;

  always_comb begin
    data = 8'h00;
    if (idx < hhdr_pkg::OFS_IF_STT) begin
      case (idx[3:0])
        4'h0: data = hhdr_pkg::OSC_LEN;
        4'h1: data = hhdr_pkg::OSC_TYPE;
        4'h2: data = lsb_first(total_len, 1'b0);
        4'h3: data = lsb_first(total_len, 1'b1);
        4'h4: data = num_if;
        4'h5: data = hhdr_pkg::CFG_VALUE;
        4'h6: data = hhdr_pkg::CFG_STR_IDX;
        4'h7: data = attr;
        4'h8: data = maxp;
        default: data = 8'h00;
      endcase
    end else if (idx >= hhdr_pkg::OFS_END) begin
      data = 8'h00;
    end else if (is_ep) begin
      case (rel_ep[2:0])
        3'h0: data = hhdr_pkg::EP_LEN;
        3'h1: data = hhdr_pkg::EP_TYPE;
        3'h2: data = hhdr_pkg::EP_ADDR;
        3'h3: data = hhdr_pkg::EP_ATTR;
        3'h4: data = lsb_first(hhdr_pkg::EP_MAX_PKT, 1'b0);
        3'h5: data = lsb_first(hhdr_pkg::EP_MAX_PKT, 1'b1);
        3'h6: data = hhdr_pkg::EP_INTERVAL;
        default: data = 8'h00;
      endcase
    end else begin
      case (rel_if[3:0])
        4'h0: data = hhdr_pkg::IF_LEN;
        4'h1: data = hhdr_pkg::IF_TYPE;
        4'h2: data = hhdr_pkg::IF_NUMBER;
        4'h3: data = in_mtt ? hhdr_pkg::IF_ALT_MTT : hhdr_pkg::IF_ALT_STT;
        4'h4: data = hhdr_pkg::IF_NUM_EP;
        4'h5: data = hhdr_pkg::IF_CLASS;
        4'h6: data = hhdr_pkg::IF_SUBCLASS;
        4'h7: data = in_mtt ? hhdr_pkg::IF_PROTO_MTT : proto_stt;
        4'h8: data = hhdr_pkg::IF_STR_IDX;
        default: data = 8'h00;
      endcase
    end
  end
endmodule : hhdr_byte_rom

/* design/hhdr_cfg_sync.sv */
`timescale 1ns/10ps
module hhdr_cfg_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level_r
);
  logic [2:0] sync_r;

  // Three stages; the level moves only when stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r  <= 3'h0;
      level_r <= 1'b0;
    end else begin
      sync_r  <= {sync_r[1:0], pin_in};
      if (sync_r[1] == sync_r[2]) begin
        level_r <= sync_r[2];
      end
    end
  end
endmodule : hhdr_cfg_sync

/* design/hhdr_desc_rom.sv */
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
// How it works
// - Configuration value byte at offset five reads 01h.
// - Configuration string index reads 00h.
// - Attributes read A0h for bus power, E0h for self power, nothing else.
// - Remote wake-up bit always set in attributes.
// - Max power byte counts 2 mA units of VBUS draw.
// - Max power follows the power source select: bus value at 0, self at 1.
// - Both max power values come from loaded configuration data.
// - Single-TT interface: 09h, 04h, 00h, 00h, one endpoint, class 09h, subclass 00h.
// - Single-TT protocol 00h with one interface, 01h with two.
// - Every interface string index reads 00h.
// - Endpoint descriptors: length 07h, type 05h, address 81h.
// - Endpoint attributes 03h, interrupt, no synchronisation.
// - Endpoint max packet size 0001h in both descriptor sets.
// - Endpoint polling interval 0Ch in both descriptor sets.
// - Multi-TT interface: alternate 01h, class 09h, subclass 00h, protocol 02h, one endpoint.
// - Multi-TT descriptors returned only when multi-translator is enabled.
// - Each interface reports exactly one endpoint besides endpoint zero.
// - Total length 0019h with multi-translator off, 0029h with it on.
module hhdr_desc_rom (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        power_source_pin,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             power_source_select,
  output logic             multi_translator_enable
);
  logic        ctrl_mtt_r;
  logic        ctrl_self_r;
  logic        ctrl_use_pin_r;
  logic [7:0]  max_power_bus_mode_r;
  logic [7:0]  max_power_self_mode_r;
  logic [5:0]  rd_idx_r;
  logic [5:0]  rd_idx_nxt;
  logic [31:0] avs_readdata_r;
  logic        ack_r;
  logic        avs_waitrequest_r;
  logic        power_source_select_r;
  logic        multi_translator_enable_r;
  logic        pin_level;
  logic [7:0]  rom_byte;

  wire logic       req       = (avs_read | avs_write) & ~ack_r;
  wire logic       wr_ctrl   = req & avs_write & (avs_address == hhdr_pkg::REG_CTRL) & avs_byteenable[0];
  wire logic       wr_power  = req & avs_write & (avs_address == hhdr_pkg::REG_POWER);
  wire logic       rd_data   = req & avs_read & (avs_address == hhdr_pkg::REG_DATA);
  wire logic       wr_data   = req & avs_write & (avs_address == hhdr_pkg::REG_DATA) & avs_byteenable[0];
  wire logic       self_sel  = ctrl_use_pin_r ? pin_level : ctrl_self_r;
  wire logic [5:0] stream_end = multi_translator_enable_r ? hhdr_pkg::OFS_END : hhdr_pkg::OFS_IF_MTT;

  hhdr_cfg_sync hhdr_cfg_sync_i (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   (power_source_pin),
    .level_r  (pin_level)
  );

  hhdr_byte_rom hhdr_byte_rom_i (
    .idx       (rd_idx_r),
    .self_pwr  (power_source_select_r),
    .mtt       (multi_translator_enable_r),
    .maxp_bus  (max_power_bus_mode_r),
    .maxp_self (max_power_self_mode_r),
    .data      (rom_byte)
  );

  always_comb begin
    rd_idx_nxt = rd_idx_r;
    if (wr_data) begin
      rd_idx_nxt = avs_writedata[5:0];
    end else if (rd_data && rd_idx_r < stream_end) begin
      rd_idx_nxt = rd_idx_r + 6'h01;
    end
  end

  // Readback mux; bit 8 flags the end of the stream
  wire logic [31:0] rd_mux =
    (avs_address == hhdr_pkg::REG_CTRL)   ? {29'h0, ctrl_use_pin_r, ctrl_self_r, ctrl_mtt_r} :
    (avs_address == hhdr_pkg::REG_POWER)  ? {16'h0, max_power_self_mode_r, max_power_bus_mode_r} :
    (avs_address == hhdr_pkg::REG_STATUS) ? {24'h0, 2'h0, rd_idx_r} :
    (avs_address == hhdr_pkg::REG_DATA)   ? {23'h0, rd_idx_r >= stream_end,
                                             (rd_idx_r >= stream_end) ? 8'h00 : rom_byte} :
                                            hhdr_pkg::UNMAPPED_VALUE;

  // One wait cycle, answer on the second edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r             <= 1'b0;
      avs_waitrequest_r <= 1'b1;
      avs_readdata_r    <= 32'h0000_0000;
    end else begin
      ack_r             <= req;
      // Own flop so the port comes straight from a register
      avs_waitrequest_r <= ~req;
      avs_readdata_r    <= req ? rd_mux : avs_readdata_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      max_power_bus_mode_r  <= hhdr_pkg::MAXP_BUS_RST;
      max_power_self_mode_r <= hhdr_pkg::MAXP_SELF_RST;
    end else if (wr_power) begin
      if (avs_byteenable[0]) max_power_bus_mode_r  <= avs_writedata[7:0];
      if (avs_byteenable[1]) max_power_self_mode_r <= avs_writedata[15:8];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_mtt_r     <= 1'b0;
      ctrl_self_r    <= 1'b0;
      ctrl_use_pin_r <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_mtt_r     <= avs_writedata[0];
      ctrl_self_r    <= avs_writedata[1];
      ctrl_use_pin_r <= avs_writedata[2];
    end
  end

  // mode registers feed length and content
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_source_select_r     <= 1'b0;
      multi_translator_enable_r <= 1'b0;
      rd_idx_r                  <= 6'h00;
    end else begin
      power_source_select_r     <= self_sel;
      multi_translator_enable_r <= ctrl_mtt_r;
      rd_idx_r                  <= rd_idx_nxt;
    end
  end

  assign avs_readdata            = avs_readdata_r;
  assign avs_waitrequest         = avs_waitrequest_r;
  assign power_source_select     = power_source_select_r;
  assign multi_translator_enable = multi_translator_enable_r;

  // Assertions on the byte stream, the max power register loads and the bus handshake
  wire logic [5:0] idx_q = rd_idx_r;
  wire logic [7:0] b     = rom_byte;

  a_cfg_value_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h05 |-> b == 8'h01) else $error("config value byte wrong");
  a_cfg_string_idx: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h06 |-> b == 8'h00) else $error("config string index wrong");
  a_attr_power_map: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h07 |-> b == (power_source_select_r ? 8'hE0 : 8'hA0)) else $error("attributes wrong");
  a_attr_remote_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h07 |-> b[5] && b[7]) else $error("remote wake bit missing");
  a_maxp_follows_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h08 |-> b == (power_source_select_r ? max_power_self_mode_r : max_power_bus_mode_r))
    else $error("max power does not follow mode");
  a_maxp_load_taken: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_power && avs_byteenable[0] |=> max_power_bus_mode_r == $past(avs_writedata[7:0]))
    else $error("max power load lost");
  a_stt_protocol: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h10 |-> b == (multi_translator_enable_r ? 8'h01 : 8'h00)) else $error("protocol wrong");
  a_ep_address: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h14 || idx_q == 6'h24 |-> b == 8'h81) else $error("endpoint address wrong");
  a_ep_interval: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h18 || idx_q == 6'h28 |-> b == 8'h0C) else $error("interval wrong");
  a_mtt_alt_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h1C |-> b == 8'h01) else $error("multi alt setting wrong");
  a_mtt_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_data && !multi_translator_enable_r && idx_q == 6'h19 |=> rd_idx_r == 6'h19)
    else $error("multi descriptors leaked");
  a_total_len_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h02 |-> b == (multi_translator_enable_r ? 8'h29 : 8'h19)) else $error("total length wrong");
  a_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    req ##1 (avs_read | avs_write) |-> !avs_waitrequest) else $error("bus answer late");
  a_wait_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
    req |=> !avs_waitrequest) else $error("waitrequest not lowered");
  a_stt_if_type: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h0A |-> b == 8'h04) else $error("interface type wrong");
  a_stt_alt_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h0C |-> b == 8'h00) else $error("single alt setting wrong");
  a_if_class_code: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h0E || idx_q == 6'h1E |-> b == 8'h09) else $error("interface class wrong");
  a_if_string_idx: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h11 || idx_q == 6'h21 |-> b == 8'h00) else $error("interface string index wrong");
  a_ep_length: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h12 || idx_q == 6'h22 |-> b == 8'h07) else $error("endpoint length wrong");
  a_ep_attributes: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h15 || idx_q == 6'h25 |-> b == 8'h03) else $error("endpoint attributes wrong");
  a_ep_max_packet: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h16 || idx_q == 6'h26 |-> b == 8'h01) else $error("endpoint packet size wrong");
  a_mtt_protocol: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h20 |-> b == 8'h02) else $error("multi protocol wrong");
  a_if_one_endpoint: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h0D || idx_q == 6'h1D |-> b == 8'h01) else $error("endpoint count wrong");
  a_low_byte_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    idx_q == 6'h03 || idx_q == 6'h17 || idx_q == 6'h27 |-> b == 8'h00) else $error("high byte out of order");
  a_data_past_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_data && rd_idx_r >= stream_end |=> avs_readdata[8:0] == 9'h100) else $error("end flag missing");
  a_stream_stop_mtt: assert property (@(posedge core_clk) disable iff (!rst_n)
    rd_data && multi_translator_enable_r && rd_idx_r == 6'h29 |=> rd_idx_r == 6'h29)
    else $error("stream ran past end");
  a_maxp_self_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_power && avs_byteenable[1] |=> max_power_self_mode_r == $past(avs_writedata[15:8]))
    else $error("self max power load lost");
  a_maxp_lane_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_power && !avs_byteenable[0] |=> max_power_bus_mode_r == $past(max_power_bus_mode_r))
    else $error("bus max power lane overwritten");

  c_read_stream: cover property (@(posedge core_clk) disable iff (!rst_n) rd_data && rd_idx_r == 6'h28);
  c_self_mode:   cover property (@(posedge core_clk) disable iff (!rst_n) power_source_select_r && idx_q == 6'h08);
  c_stt_end:     cover property (@(posedge core_clk) disable iff (!rst_n) rd_data && rd_idx_r == 6'h19);
  c_strap_self:  cover property (@(posedge core_clk) disable iff (!rst_n) ctrl_use_pin_r && power_source_select_r);
  c_mtt_length:  cover property (@(posedge core_clk) disable iff (!rst_n)
    rd_data && multi_translator_enable_r && rd_idx_r == 6'h02);
endmodule : hhdr_desc_rom

/* test/hhdr_host_model.sv */
`timescale 1ns/10ps
// Avalon master standing in for the enumerating host
module hhdr_host_model (
  input  wire logic        core_clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic [3:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable
);
  initial begin
    avs_address    = 4'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // Held until waitrequest is sampled low; a new call always lets one edge pass first
  task automatic xfer(input logic wr, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] be,
                      output logic [31:0] rd);
    @(posedge core_clk);
    avs_address    <= adr;
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : xfer
endmodule : hhdr_host_model

/* test/test_hhdr_desc_rom.sv */
`timescale 1ns/10ps
module test_hhdr_desc_rom;
  logic        core_clk;
  logic        rst_n;
  logic        power_source_pin;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        power_source_select;
  logic        multi_translator_enable;
  logic [31:0] rd;
  logic        m;
  logic        s;
  logic [7:0]  pb;
  logic [7:0]  ps;
  int          n_errors;
  int          comparisons;
  int          cycles;
  int          n;

  hhdr_desc_rom hhdr_desc_rom_i (
    .core_clk(core_clk), .rst_n(rst_n), .power_source_pin(power_source_pin),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .power_source_select(power_source_select), .multi_translator_enable(multi_translator_enable)
  );

  hhdr_host_model hhdr_host_model_i (
    .core_clk(core_clk), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable)
  );

  always #5 core_clk = ~core_clk;

  // Whole run needs well under 2000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      $display("FAIL %0t run did not finish", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic br(input logic [3:0] a);
    hhdr_host_model_i.xfer(1'b0, a, 32'h0000_0000, 4'hF, rd);
  endtask : br

  task automatic bw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] unused;
    hhdr_host_model_i.xfer(1'b1, a, d, be, unused);
  endtask : bw

  // Reference stream: whole cfg descriptor, single-TT if and ep, then multi-TT if and ep
  function automatic logic [7:0] exp_byte(input int i, input logic mt, input logic sp, input logic [7:0] vb,
                                          input logic [7:0] vs);
    logic [7:0] t [41];
    t = '{8'h09, 8'h07, (mt ? 8'h29 : 8'h19), 8'h00, (mt ? 8'h02 : 8'h01), 8'h01, 8'h00, (sp ? 8'hE0 : 8'hA0),
          (sp ? vs : vb),
          8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, (mt ? 8'h01 : 8'h00), 8'h00,
          8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0C,
          8'h09, 8'h04, 8'h00, 8'h01, 8'h01, 8'h09, 8'h00, 8'h02, 8'h00,
          8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0C};
    return t[i];
  endfunction : exp_byte

  initial begin
    core_clk         = 1'b0;
    rst_n            = 1'b0;
    power_source_pin = 1'b0;
    n_errors         = 0;
    comparisons      = 0;
    cycles           = 0;
    repeat (5) @(posedge core_clk);
    chk(avs_readdata, 32'h0000_0000, "reset readdata");
    chk({29'h0, avs_waitrequest, power_source_select, multi_translator_enable}, 32'h4, "reset outputs");
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    br(hhdr_pkg::REG_POWER);
    chk(rd & 32'h0000_FFFF, 32'h0000_0132, "power defaults");
    // Partial lanes: self value only, then a control write without lane zero
    bw(hhdr_pkg::REG_POWER, 32'h0000_7E7E, 4'h2);
    br(hhdr_pkg::REG_POWER);
    chk(rd & 32'h0000_FFFF, {16'h0, 8'h7E, hhdr_pkg::MAXP_BUS_RST}, "power self lane");
    bw(hhdr_pkg::REG_CTRL, 32'h0000_0007, 4'hE);
    br(hhdr_pkg::REG_CTRL);
    chk({29'h0, rd[2:0]}, 32'h0000_0000, "ctrl needs lane zero");
    for (int c = 0; c < 4; c++) begin
      m  = c[0];
      s  = c[1];
      pb = {6'h04, c[1:0]};
      ps = {6'h20, c[1:0]};
      bw(hhdr_pkg::REG_CTRL, {29'h0, 1'b0, s, m});
      bw(hhdr_pkg::REG_POWER, {16'h0000, ps, pb});
      chk({30'h0, power_source_select, multi_translator_enable}, {30'h0, s, m}, "mode outputs");
      bw(hhdr_pkg::REG_DATA, 32'h0000_0000);
      n = m ? 41 : 25;
      for (int i = 0; i < n; i++) begin
        br(hhdr_pkg::REG_DATA);
        chk({23'h0, rd[8:0]}, {24'h0, exp_byte(i, m, s, pb, ps)}, "stream byte");
      end
      br(hhdr_pkg::REG_DATA);
      chk({23'h0, rd[8:0]}, 32'h0000_0100, "end of stream");
      br(hhdr_pkg::REG_STATUS);
      chk({26'h0, rd[5:0]}, n, "index at end");
    end
    for (int p = 1; p >= 0; p--) begin
      power_source_pin <= p[0];
      bw(hhdr_pkg::REG_CTRL, 32'h0000_0004);
      repeat (6) @(posedge core_clk);
      chk({31'h0, power_source_select}, {31'h0, p[0]}, "strap mode");
      bw(hhdr_pkg::REG_DATA, 32'h0000_0007);
      br(hhdr_pkg::REG_DATA);
      chk({24'h0, rd[7:0]}, (p[0] ? 32'hE0 : 32'hA0), "strap attributes");
      br(hhdr_pkg::REG_DATA);
      chk({24'h0, rd[7:0]}, {24'h0, (p[0] ? ps : pb)}, "strap max power");
    end
    br(4'h2);
    chk(rd, hhdr_pkg::UNMAPPED_VALUE, "unmapped read");
    bw(4'h2, 32'hFFFF_FFFF);
    br(hhdr_pkg::REG_CTRL);
    chk({29'h0, rd[2:0]}, 32'h0000_0004, "ctrl after unmapped write");
    test_done();
  end
endmodule : test_hhdr_desc_rom
